// ---- design/qpt_pkg.sv ----
// Package for the quadrature position timer block.
// Assumes a 32-bit APB slave with word-aligned registers.

package qpt_pkg;

	// ********************************************************
	// Register byte offsets
	// ********************************************************
	localparam logic [7:0] OFS_POSITION_COUNT = 8'h00;
	localparam logic [7:0] OFS_POSITION_INIT_VALUE = 8'h04;
	localparam logic [7:0] OFS_POSITION_MAX_VALUE = 8'h08;
	localparam logic [7:0] OFS_POSITION_COMPARE_VALUE = 8'h0C;
	localparam logic [7:0] OFS_INDEX_POSITION_LATCH = 8'h10;
	localparam logic [7:0] OFS_STROBE_POSITION_LATCH = 8'h14;
	localparam logic [7:0] OFS_PERIODIC_POSITION_LATCH = 8'h18;
	localparam logic [7:0] OFS_UNIT_TIMER_COUNT = 8'h1C;
	localparam logic [7:0] OFS_UNIT_TIMER_PERIOD = 8'h20;
	localparam logic [7:0] OFS_STALL_TIMER_COUNT = 8'h24;
	localparam logic [7:0] OFS_STALL_TIMER_PERIOD = 8'h28;
	localparam logic [7:0] OFS_EVENT_ENABLE_MASK = 8'h2C;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h30;
	localparam logic [7:0] OFS_CONTROL = 8'h34;

	// ********************************************************
	// Event bit positions (enable mask and flags share them)
	// ********************************************************
	localparam int EV_UNIT_TIMEOUT = 11;
	localparam int EV_INDEX_LATCH = 10;
	localparam int EV_STROBE_LATCH = 9;
	localparam int EV_COMPARE_MATCH = 8;
	localparam int EV_COMPARE_READY = 7;
	localparam int EV_OVERFLOW = 6;
	localparam int EV_UNDERFLOW = 5;
	localparam int EV_STALL_TIMEOUT = 4;
	localparam int EV_DIRECTION_CHANGE = 3;
	localparam int EV_PHASE_ERROR = 2;
	localparam int EV_COUNT_ERROR = 1;
	localparam logic [15:0] EVENT_MASK_WRITABLE = 16'h0FFE;
	localparam logic [15:0] EVENT_MASK_RESET = 16'h0000;

	// ********************************************************
	// Control register bit positions
	// ********************************************************
	localparam int CTL_INDEX_INIT = 0;
	localparam int CTL_STROBE_INIT = 1;
	localparam int CTL_INDEX_LATCH_SELECT = 2;
	localparam int CTL_STROBE_LATCH_SELECT = 3;
	localparam int CTL_UNIT_TIMER_ENABLE = 4;
	localparam int CTL_STALL_TIMER_ENABLE = 5;
	localparam int CTL_COMPARE_ENABLE = 6;
	localparam int CTL_SYNC_ENABLE = 7;
	localparam int CTL_SOFT_INIT = 8;
	localparam logic [8:0] CONTROL_RESET = 9'h000;

	// ********************************************************
	// Reset values and widths
	// ********************************************************
	localparam logic [31:0] POSITION_RESET = 32'h0000_0000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [15:0] HALF_RESET = 16'h0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// Encoder-side inputs travel together
	typedef struct packed {
		logic count_pulse;
		logic direction_up;
		logic quad_clock;
		logic index_event;
		logic strobe_event;
		logic direction_change;
		logic phase_error;
		logic count_error;
	} qpt_enc_t;

endpackage

// ---- design/qpt_top.sv ----
// Quadrature position timer: position counter, latches, unit timer,
// stall watchdog and event enable/flag registers behind an APB slave.
// Assumes decoded encoder events arrive synchronous to pclk.
//
// What this block does
// - 32-bit position counter steps up or down on each decoded pulse.
// - Init value loads into counter on enabled strobe or index event.
// - Software may load the counter directly, besides event loading.
// - Software-writable 32-bit maximum limits the counter range.
// - Index event copies counter into index latch when selected.
// - Strobe event copies counter into strobe latch when selected.
// - Unit timeout copies counter into periodic latch.
// - 32-bit unit timer raises unit event when equal to period.
// - Unit period gives regular events, latching and optional interrupt.
// - 16-bit watchdog timer is the time base for stall detection.
// - Each quadrature clock edge clears the watchdog timer.
// - Watchdog equal to its period raises a timeout event.
// - Every event source has its own enable bit, all off at reset.
// - Index and strobe latch flags set in the same cycle as their latch copies.
// - Compare match flag, and compare ready flag on each compare value write.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module qpt_top #(
	parameter int POS_W = 32,
	parameter int STALL_W = 16
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Encoder events
	input wire qpt_pkg::qpt_enc_t enc,
	// Outputs
	output logic sync_out,
	output logic event_out
);

	// ********************************************************
	// Register state
	// ********************************************************
	logic [POS_W-1:0] position_count_r;
	logic [POS_W-1:0] position_init_value_r;
	logic [POS_W-1:0] position_max_value_r;
	logic [POS_W-1:0] position_compare_value_r;
	logic [POS_W-1:0] index_position_latch_r;
	logic [POS_W-1:0] strobe_position_latch_r;
	logic [POS_W-1:0] periodic_position_latch_r;
	logic [31:0] unit_timer_count_r;
	logic [31:0] unit_timer_period_r;
	logic [STALL_W-1:0] stall_timer_count_r;
	logic [STALL_W-1:0] stall_timer_period_r;
	logic [15:0] event_enable_mask_r;
	logic [15:0] event_flags_r;
	logic [8:0] control_r;
	logic quad_clock_r;
	logic compare_hit_r;
	// Next values, strobes and decoded events
	logic [POS_W-1:0] position_count_nxt;
	logic rd_setup;
	logic [15:0] event_set;
	logic wr_en;
	logic unit_event;
	logic stall_event;
	logic quad_edge;
	logic compare_hit;
	logic overflow;
	logic underflow;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = clk_en & psel & penable & pwrite;
	// Read data is captured in the setup cycle, so pready can stay high;
	// gating it with clk_en keeps prdata frozen along with all other state
	assign rd_setup = clk_en & psel & ~penable & ~pwrite;

	// ********************************************************
	// Event detection
	// ********************************************************
	// Unit event when timer reaches period
	assign unit_event = control_r[qpt_pkg::CTL_UNIT_TIMER_ENABLE]
		& (unit_timer_count_r == unit_timer_period_r);
	// Stall timeout when watchdog reaches period
	assign stall_event = control_r[qpt_pkg::CTL_STALL_TIMER_ENABLE]
		& (stall_timer_count_r == stall_timer_period_r);
	// Either edge of the quadrature clock; the copy idles low like the pin
	assign quad_edge = enc.quad_clock ^ quad_clock_r;
	// Continuous equality
	assign compare_hit = control_r[qpt_pkg::CTL_COMPARE_ENABLE]
		& (position_count_r == position_compare_value_r);
	// Wrap detection at the two ends of the counting range
	assign overflow = enc.count_pulse & enc.direction_up
		& (position_count_r == position_max_value_r);
	assign underflow = enc.count_pulse & ~enc.direction_up
		& (position_count_r == '0);

	// Sources gathered at their flag positions
	always_comb
	begin
		event_set = 16'h0000;
		event_set[qpt_pkg::EV_UNIT_TIMEOUT] = unit_event;
		event_set[qpt_pkg::EV_INDEX_LATCH] = enc.index_event
			& control_r[qpt_pkg::CTL_INDEX_LATCH_SELECT];
		event_set[qpt_pkg::EV_STROBE_LATCH] = enc.strobe_event
			& control_r[qpt_pkg::CTL_STROBE_LATCH_SELECT];
		event_set[qpt_pkg::EV_COMPARE_MATCH] = compare_hit & ~compare_hit_r;
		// Compare ready follows every compare write; there is no shadow stage
		event_set[qpt_pkg::EV_COMPARE_READY] = wr_en
			& (paddr == qpt_pkg::OFS_POSITION_COMPARE_VALUE);
		event_set[qpt_pkg::EV_OVERFLOW] = overflow;
		event_set[qpt_pkg::EV_UNDERFLOW] = underflow;
		event_set[qpt_pkg::EV_STALL_TIMEOUT] = stall_event;
		event_set[qpt_pkg::EV_DIRECTION_CHANGE] = enc.direction_change;
		event_set[qpt_pkg::EV_PHASE_ERROR] = enc.phase_error;
		event_set[qpt_pkg::EV_COUNT_ERROR] = enc.count_error;
	end

	// ********************************************************
	// Position counter
	// ********************************************************
	// Priority: software write, then event init, then counting
	// Overflow and underflow wrap between zero and the maximum
	always_comb
	begin
		position_count_nxt = position_count_r;
		if (wr_en && paddr == qpt_pkg::OFS_POSITION_COUNT)
			position_count_nxt = pwdata[POS_W-1:0];
		else if (wr_en && paddr == qpt_pkg::OFS_CONTROL
			&& pwdata[qpt_pkg::CTL_SOFT_INIT])
			position_count_nxt = position_init_value_r;
		else if ((enc.index_event && control_r[qpt_pkg::CTL_INDEX_INIT])
			|| (enc.strobe_event && control_r[qpt_pkg::CTL_STROBE_INIT]))
			position_count_nxt = position_init_value_r;
		else if (overflow)
			position_count_nxt = '0; // Wrap at maximum
		else if (underflow)
			position_count_nxt = position_max_value_r;
		else if (enc.count_pulse && enc.direction_up)
			position_count_nxt = position_count_r + 1'b1;
		else if (enc.count_pulse)
			position_count_nxt = position_count_r - 1'b1;
	end

	// Held while clk_en is low, like every other register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			position_count_r <= qpt_pkg::POSITION_RESET;
		else if (clk_en)
			position_count_r <= position_count_nxt;
	end

	// ********************************************************
	// Software-written setup registers
	// ********************************************************
	// Only bus writes reach these; no hardware path updates them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			position_init_value_r <= '0;
			position_max_value_r <= '0;
			position_compare_value_r <= '0;
			unit_timer_period_r <= qpt_pkg::WORD_RESET;
			stall_timer_period_r <= '0;
			event_enable_mask_r <= qpt_pkg::EVENT_MASK_RESET;
			control_r <= qpt_pkg::CONTROL_RESET;
		end
		else if (wr_en)
		begin
			if (paddr == qpt_pkg::OFS_POSITION_INIT_VALUE)
				position_init_value_r <= pwdata[POS_W-1:0];
			else if (paddr == qpt_pkg::OFS_POSITION_MAX_VALUE)
				position_max_value_r <= pwdata[POS_W-1:0];
			else if (paddr == qpt_pkg::OFS_POSITION_COMPARE_VALUE)
				position_compare_value_r <= pwdata[POS_W-1:0];
			else if (paddr == qpt_pkg::OFS_UNIT_TIMER_PERIOD)
				unit_timer_period_r <= pwdata;
			else if (paddr == qpt_pkg::OFS_STALL_TIMER_PERIOD)
				stall_timer_period_r <= pwdata[STALL_W-1:0];
			else if (paddr == qpt_pkg::OFS_EVENT_ENABLE_MASK)
				event_enable_mask_r <= pwdata[15:0] & qpt_pkg::EVENT_MASK_WRITABLE;
			else if (paddr == qpt_pkg::OFS_CONTROL)
				control_r <= {1'b0, pwdata[7:0]}; // Soft init is self-clearing
		end
	end

	// ********************************************************
	// Position latches
	// ********************************************************
	// Latches copy the count as it stood before this edge's update
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			index_position_latch_r <= '0;
			strobe_position_latch_r <= '0;
			periodic_position_latch_r <= '0;
		end
		else if (clk_en)
		begin
			if (event_set[qpt_pkg::EV_INDEX_LATCH])
				index_position_latch_r <= position_count_r;
			if (event_set[qpt_pkg::EV_STROBE_LATCH])
				strobe_position_latch_r <= position_count_r;
			if (unit_event)
				periodic_position_latch_r <= position_count_r;
		end
	end

	// ********************************************************
	// Unit timer
	// ********************************************************
	// A software write wins over the restart so the timer can be preset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			unit_timer_count_r <= qpt_pkg::WORD_RESET;
		else if (clk_en)
		begin
			if (wr_en && paddr == qpt_pkg::OFS_UNIT_TIMER_COUNT)
				unit_timer_count_r <= pwdata;
			else if (unit_event)
				unit_timer_count_r <= qpt_pkg::WORD_RESET;
			else if (control_r[qpt_pkg::CTL_UNIT_TIMER_ENABLE])
				unit_timer_count_r <= unit_timer_count_r + 32'h0000_0001;
		end
	end

	// ********************************************************
	// Stall watchdog
	// ********************************************************
	// Motion restarts the count; a timeout also restarts it to rearm
	// The clear on an edge acts even while the watchdog is off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stall_timer_count_r <= '0;
			quad_clock_r <= 1'b0;
		end
		else if (clk_en)
		begin
			quad_clock_r <= enc.quad_clock;
			if (wr_en && paddr == qpt_pkg::OFS_STALL_TIMER_COUNT)
				stall_timer_count_r <= pwdata[STALL_W-1:0];
			else if (quad_edge || stall_event)
				stall_timer_count_r <= '0;
			else if (control_r[qpt_pkg::CTL_STALL_TIMER_ENABLE])
				stall_timer_count_r <= stall_timer_count_r + 1'b1;
		end
	end

	// ********************************************************
	// Event flags and outputs
	// ********************************************************
	// Write-one-to-clear; a new event in the same cycle wins
	// Reserved bits stay zero since no source drives them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			event_flags_r <= qpt_pkg::HALF_RESET;
		else if (clk_en)
		begin
			if (wr_en && paddr == qpt_pkg::OFS_EVENT_FLAGS)
				event_flags_r <= (event_flags_r & ~pwdata[15:0]) | event_set;
			else
				event_flags_r <= event_flags_r | event_set;
		end
	end

	// Sync pulse in the cycle after the first cycle of a match
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			compare_hit_r <= 1'b0;
			sync_out <= 1'b0;
			event_out <= 1'b0;
		end
		else if (clk_en)
		begin
			compare_hit_r <= compare_hit;
			sync_out <= compare_hit & ~compare_hit_r & control_r[qpt_pkg::CTL_SYNC_ENABLE];
			// Level output; software drops it by clearing the flag
			event_out <= |(event_flags_r & event_enable_mask_r);
		end
	end

	// ********************************************************
	// APB read mux
	// ********************************************************
	// Registered read data, loaded in the setup cycle
	// A count read shows the value one cycle before the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= qpt_pkg::UNMAPPED_READ;
		else if (rd_setup)
		begin
			if (paddr == qpt_pkg::OFS_POSITION_COUNT)
				prdata <= 32'(position_count_r);
			else if (paddr == qpt_pkg::OFS_POSITION_INIT_VALUE)
				prdata <= 32'(position_init_value_r);
			else if (paddr == qpt_pkg::OFS_POSITION_MAX_VALUE)
				prdata <= 32'(position_max_value_r);
			else if (paddr == qpt_pkg::OFS_POSITION_COMPARE_VALUE)
				prdata <= 32'(position_compare_value_r);
			else if (paddr == qpt_pkg::OFS_INDEX_POSITION_LATCH)
				prdata <= 32'(index_position_latch_r);
			else if (paddr == qpt_pkg::OFS_STROBE_POSITION_LATCH)
				prdata <= 32'(strobe_position_latch_r);
			else if (paddr == qpt_pkg::OFS_PERIODIC_POSITION_LATCH)
				prdata <= 32'(periodic_position_latch_r);
			else if (paddr == qpt_pkg::OFS_UNIT_TIMER_COUNT)
				prdata <= unit_timer_count_r;
			else if (paddr == qpt_pkg::OFS_UNIT_TIMER_PERIOD)
				prdata <= unit_timer_period_r;
			else if (paddr == qpt_pkg::OFS_STALL_TIMER_COUNT)
				prdata <= 32'(stall_timer_count_r);
			else if (paddr == qpt_pkg::OFS_STALL_TIMER_PERIOD)
				prdata <= 32'(stall_timer_period_r);
			else if (paddr == qpt_pkg::OFS_EVENT_ENABLE_MASK)
				prdata <= {16'h0000, event_enable_mask_r};
			else if (paddr == qpt_pkg::OFS_EVENT_FLAGS)
				prdata <= {16'h0000, event_flags_r};
			else if (paddr == qpt_pkg::OFS_CONTROL)
				prdata <= {23'h000000, control_r};
			// Unmapped offsets read as zero
			else
				prdata <= qpt_pkg::UNMAPPED_READ;
		end
	end

endmodule // qpt_top

// ---- verification/qpt_top_checker.sv ----
// Checker for the quadrature position timer's APB and event ports.
// Assumes it is bound into qpt_top and sees only that module's ports.
`timescale 1ns/1ps

module qpt_top_checker #(
	parameter int STALL_W = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Outputs
	input wire logic sync_out,
	input wire logic event_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] mask_r;
	logic sync_en_r;
	logic rd_setup;
	logic wr_done;
	// Read setup and completed write, as the slave sees them
	assign rd_setup = psel && !penable && !pwrite && clk_en;
	assign wr_done = psel && penable && pwrite && clk_en;
	// Shadow of what software wrote to the mask and the sync enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_r <= 16'h0000;
			sync_en_r <= 1'b0;
		end
		else if (wr_done && paddr == 8'h2C)
			mask_r <= pwdata[15:0] & 16'h0FFE;
		else if (wr_done && paddr == 8'h34)
			sync_en_r <= pwdata[7];
	end
	// ****************************************
	// Port relations
	// ****************************************
	chk_no_error: assert property (pslverr == 1'b0)
		else $error("slave error raised");
	chk_ready_high: assert property (pready == 1'b1)
		else $error("ready low");
	chk_read_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved");
	chk_unmapped_zero: assert property (rd_setup && paddr > 8'h34 |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_mask_readback: assert property (rd_setup && paddr == 8'h2C |=> prdata == {16'h0, mask_r})
		else $error("enable mask readback wrong");
	chk_stall_width: assert property (rd_setup && paddr inside {8'h24, 8'h28} |=> prdata[31:STALL_W] == '0)
		else $error("stall word too wide");
	chk_event_masked: assert property (event_out |-> (mask_r != 16'h0 || $past(mask_r) != 16'h0))
		else $error("event with all enables off");
	chk_sync_single: assert property (sync_out |=> !sync_out)
		else $error("sync pulse longer than one cycle");
	chk_sync_enabled: assert property (sync_out |-> (sync_en_r || $past(sync_en_r)))
		else $error("sync pulse while disabled");
endmodule // qpt_top_checker

bind qpt_top qpt_top_checker #(.STALL_W(STALL_W)) qpt_top_checker_i (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sync_out(sync_out), .event_out(event_out));

// ---- verification/qpt_encoder_model.sv ----
// Encoder model: decoded steps, index and strobe markers for the block.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps

module qpt_encoder_model (
	// Clock
	input wire logic pclk,
	// Decoded encoder signals
	output qpt_pkg::qpt_enc_t enc
);
	// Quiet levels from time zero
	initial enc = '0;
	// One step; quad_clock toggles as a real edge would
	task automatic step(input bit up);
		@(posedge pclk);
		enc.count_pulse <= 1'b1;
		enc.direction_change <= (up != enc.direction_up);
		enc.direction_up <= up;
		enc.quad_clock <= ~enc.quad_clock;
		@(posedge pclk);
		enc.count_pulse <= 1'b0;
		enc.direction_change <= 1'b0;
	endtask
	// One-cycle marker: index when sel is 0, strobe when 1
	task automatic marker(input bit sel);
		@(posedge pclk);
		enc.index_event <= !sel;
		enc.strobe_event <= sel;
		@(posedge pclk);
		enc.index_event <= 1'b0;
		enc.strobe_event <= 1'b0;
	endtask
	// One-cycle decoder fault: phase error when sel is 0, count error when 1
	task automatic fault(input bit sel);
		@(posedge pclk);
		enc.phase_error <= !sel;
		enc.count_error <= sel;
		@(posedge pclk);
		enc.phase_error <= 1'b0;
		enc.count_error <= 1'b0;
	endtask
endmodule // qpt_encoder_model

// ---- verification/testbench.sv ----
// Self-checking bench for the quadrature position timer.
// Assumes the encoder model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sync_out;
	logic event_out;
	qpt_pkg::qpt_enc_t enc;
	int n_mismatch = 0;
	int checked = 0;
	int seed = 32'h3154;
	int cnt = 0;
	int mx = 0;
	int fl = 0;
	int dir = 0;
	int i;
	logic [31:0] r;
	logic [31:0] v;
	logic [7:0] ofs [11] = '{8'h04, 8'h08, 8'h0C, 8'h20, 8'h28, 8'h2C, 8'h1C, 8'h24, 8'h10, 8'h14,
		8'h18};
	logic [31:0] msk [11] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFF,
		32'h0FFE, 32'hFFFFFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0};

	// 10 MHz clock
	always #50 pclk = ~pclk;

	qpt_top qpt_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enc(enc), .sync_out(sync_out), .event_out(event_out));
	qpt_encoder_model qpt_encoder_model_i (.pclk(pclk), .enc(enc));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; read data taken at the edge that sees pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Step the encoder and the reference count, wrapping at the maximum
	task automatic step(input bit up);
		qpt_encoder_model_i.step(up);
		fl |= (up && cnt == mx) ? 32'h40 : ((!up && cnt == 0) ? 32'h20 : 0);
		fl |= (up != dir) ? 32'h08 : 0;
		cnt = up ? ((cnt == mx) ? 0 : cnt + 1) : ((cnt == 0) ? mx : cnt - 1);
		dir = up;
	endtask
	task automatic report_and_stop;
		if (n_mismatch == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog far beyond the few hundred cycles the run needs
	initial
	begin
		#(100 * 20000);
		n_mismatch++;
		report_and_stop;
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// Every word reads zero after reset, unmapped one too
		for (i = 0; i <= 8'h38; i += 4)
		begin
			xfer(1'b0, i[7:0], 32'h0);
			chk(r, 32'h0);
		end
		// Random words through each place; latches stay read-only
		for (i = 0; i < 11; i++)
		begin
			v = $random(seed);
			xfer(1'b1, ofs[i], v);
			xfer(1'b0, ofs[i], 32'h0);
			chk(r, v & msk[i]);
		end
		xfer(1'b1, 8'h2C, 32'h0);
		// Random walk across both wrap points with a maximum of five
		mx = 5;
		cnt = 2;
		xfer(1'b1, 8'h08, 32'd5);
		xfer(1'b1, 8'h00, 32'd2);
		xfer(1'b1, 8'h30, 32'hFFFF);
		for (i = 0; i < 40; i++)
		begin
			v = $random(seed);
			step(v[0]);
		end
		xfer(1'b0, 8'h00, 32'h0);
		chk(r, cnt);
		xfer(1'b0, 8'h30, 32'h0);
		chk(r & 32'h68, fl);
		// Index and strobe copy the count into their latches
		xfer(1'b1, 8'h34, 32'h0C);
		qpt_encoder_model_i.marker(1'b0);
		qpt_encoder_model_i.marker(1'b1);
		qpt_encoder_model_i.fault(1'b0);
		qpt_encoder_model_i.fault(1'b1);
		xfer(1'b0, 8'h10, 32'h0);
		chk(r, cnt);
		xfer(1'b0, 8'h14, 32'h0);
		chk(r, cnt);
		xfer(1'b0, 8'h30, 32'h0);
		chk(r & 32'h600, 32'h600);
		chk(r & 32'h6, 32'h6);
		// Index, strobe and software each load the init value
		xfer(1'b1, 8'h04, 32'd3);
		xfer(1'b1, 8'h34, 32'h01);
		qpt_encoder_model_i.marker(1'b0);
		xfer(1'b0, 8'h00, 32'h0);
		chk(r, 32'd3);
		xfer(1'b1, 8'h00, 32'd1);
		xfer(1'b1, 8'h34, 32'h02);
		qpt_encoder_model_i.marker(1'b1);
		xfer(1'b0, 8'h00, 32'h0);
		chk(r, 32'd3);
		xfer(1'b1, 8'h00, 32'd0);
		xfer(1'b1, 8'h34, 32'h100);
		xfer(1'b0, 8'h00, 32'h0);
		chk(r, 32'd3);
		cnt = 3;
		// Compare match one step away, with sync and an enabled event
		xfer(1'b1, 8'h30, 32'hFFFF);
		xfer(1'b1, 8'h2C, 32'h100);
		xfer(1'b1, 8'h0C, 32'd4);
		xfer(1'b1, 8'h34, 32'hC0);
		step(1'b1);
		i = 0;
		while (sync_out !== 1'b1 && i < 6)
		begin
			@(negedge pclk);
			i++;
		end
		chk(sync_out, 1'b1);
		repeat (2) @(negedge pclk);
		chk(event_out, 1'b1);
		xfer(1'b0, 8'h30, 32'h0);
		chk(r & 32'h180, 32'h180);
		xfer(1'b1, 8'h30, 32'hFFFF);
		repeat (3) @(negedge pclk);
		chk(event_out, 1'b0);
		// Unit timer of period seven never passes it and latches the count
		xfer(1'b1, 8'h20, 32'd7);
		xfer(1'b1, 8'h1C, 32'd0);
		xfer(1'b1, 8'h34, 32'h10);
		for (i = 0; i < 12; i++)
		begin
			xfer(1'b0, 8'h1C, 32'h0);
			chk(r > 32'd7, 1'b0);
		end
		xfer(1'b0, 8'h18, 32'h0);
		chk(r, cnt);
		xfer(1'b0, 8'h30, 32'h0);
		chk(r[11], 1'b1);
		// Steady motion keeps the stall watchdog quiet, a pause trips it
		xfer(1'b1, 8'h28, 32'd20);
		xfer(1'b1, 8'h24, 32'd0);
		xfer(1'b1, 8'h34, 32'h20);
		xfer(1'b1, 8'h30, 32'hFFFF);
		for (i = 0; i < 4; i++)
		begin
			step(1'b1);
			repeat (8) @(posedge pclk);
		end
		xfer(1'b0, 8'h30, 32'h0);
		chk(r[4], 1'b0);
		repeat (30) @(posedge pclk);
		xfer(1'b0, 8'h30, 32'h0);
		chk(r[4], 1'b1);
		// With clk_en low a write and a step are both lost
		clk_en <= 1'b0;
		xfer(1'b1, 8'h00, 32'h55);
		qpt_encoder_model_i.step(1'b1);
		clk_en <= 1'b1;
		xfer(1'b0, 8'h00, 32'h0);
		chk(r, cnt);
		// A reset in mid-run clears the count, the enables and the control
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0);
		xfer(1'b0, 8'h2C, 32'h0);
		chk(r, 32'h0);
		xfer(1'b0, 8'h34, 32'h0);
		chk(r, 32'h0);
		chk(event_out, 1'b0);
		report_and_stop;
	end
endmodule // testbench
